//--- hw/qhb_ctrl.sv
// Top of the quad half-bridge drive controller: registers, phase
// generation and the sequencer that walks the stage through power-up.
// Assumes FAULT_N and HOT_ALERT_N are synchronous to CLOCK and pulled up.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module qhb_ctrl (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  output logic POWER_DOWN_N,
  output logic OUT_FLOAT_N,
  output logic LOGIC_SUPPLY_EN,
  output logic [1:0] PHASE_A_IN,
  output logic [1:0] PHASE_B_IN,
  input wire logic FAULT_N,
  input wire logic HOT_ALERT_N
);

  // ****************************************
  // Software registers
  // ****************************************
  logic ctrl_run_q; // Request the stage to run
  logic ctrl_auto_q; // Retry on fault by itself
  logic [1:0] ctrl_mode_q; // Ternary, binary or parallel
  logic [qhb_pkg::DUTY_SIGN:0] duty_q [qhb_pkg::NCH]; // Duty and sign
  logic [qhb_pkg::IRQ_W-1:0] irq_stat_q; // Sticky events
  logic [qhb_pkg::IRQ_W-1:0] irq_mask_q; // Enables onto IRQ
  logic [qhb_pkg::IRQ_W-1:0] irq_set; // Events this cycle
  logic rearm_pulse; // One-cycle restart order
  logic [31:0] rdata_q; // Read data, valid the cycle after RD

  logic wr_ctrl;
  logic wr_cmd;
  assign wr_ctrl = WR && (ADDR == qhb_pkg::REG_CTRL);
  assign wr_cmd = WR && (ADDR == qhb_pkg::REG_CMD);
  assign rearm_pulse = wr_cmd && WDATA[qhb_pkg::CMD_REARM];

  // Control register
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl_run_q <= 1'b0;
      ctrl_auto_q <= 1'b0;
      ctrl_mode_q <= qhb_pkg::MODE_TERN;
    end
    else if (CLK_EN && wr_ctrl)
    begin
      ctrl_run_q <= WDATA[qhb_pkg::CTRL_RUN];
      ctrl_auto_q <= WDATA[qhb_pkg::CTRL_AUTO];
      ctrl_mode_q <= WDATA[qhb_pkg::CTRL_MODE_LO +: 2];
    end
  end

  // Duty registers, one per channel
  genvar gd;
  generate
    for (gd = 0; gd < qhb_pkg::NCH; gd++)
    begin : g_duty
      logic [7:0] duty_addr;
      assign duty_addr = qhb_pkg::REG_DUTY0 + 8'(gd * 4);
      always_ff @(posedge CLOCK or negedge RESETN)
      begin
        if (!RESETN)
          duty_q[gd] <= '0;
        else if (CLK_EN && WR && ADDR == duty_addr)
          duty_q[gd] <= WDATA[qhb_pkg::DUTY_SIGN:0];
      end
    end
  endgenerate

  // ****************************************
  // Sequencer
  // ****************************************
  logic seq_pd_n; // Power-down pin level
  logic seq_float_n; // Float pin level
  logic seq_logic_en; // Logic reference enable
  logic seq_phase_en; // Phases may switch
  qhb_pkg::qhb_state_t seq_state; // For status readback

  qhb_seq u_seq (
    .clk(CLOCK),
    .rst_n(RESETN),
    .ce(CLK_EN),
    .run_req(ctrl_run_q),
    .auto_retry(ctrl_auto_q),
    .rearm(rearm_pulse),
    .fault_n(FAULT_N),
    .power_down_n(seq_pd_n),
    .float_n(seq_float_n),
    .logic_en(seq_logic_en),
    .phase_en(seq_phase_en),
    .state(seq_state)
  );

  assign POWER_DOWN_N = seq_pd_n;
  assign OUT_FLOAT_N = seq_float_n;
  assign LOGIC_SUPPLY_EN = seq_logic_en;

  // ****************************************
  // Phase generation
  // ****************************************
  logic [qhb_pkg::DUTY_W-1:0] pwm_cnt_q; // Shared carrier ramp
  logic [1:0] pha_q; // Registered phase A per channel
  logic [1:0] phb_q; // Registered phase B per channel

  // Free-running ramp; both channels share edges
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      pwm_cnt_q <= '0;
    else if (CLK_EN)
      pwm_cnt_q <= pwm_cnt_q + 1'b1;
  end

  genvar gc;
  generate
    for (gc = 0; gc < qhb_pkg::NCH; gc++)
    begin : g_phase
      logic on; // Pulse active for this channel
      logic a_d;
      logic b_d;
      assign on = pwm_cnt_q < duty_q[gc][qhb_pkg::DUTY_W-1:0];
      // Pair code per mode; ternary off time is the damped 00 code
      always_comb
      begin
        a_d = 1'b0;
        b_d = 1'b0;
        if (!seq_phase_en)
        begin
          // Idle pins while floated, stopping or shut down
          a_d = 1'b0;
          b_d = 1'b0;
        end
        else if (ctrl_mode_q == qhb_pkg::MODE_PAR)
        begin
          // Joined outputs need identical phases
          a_d = on;
          b_d = on;
        end
        else if (ctrl_mode_q == qhb_pkg::MODE_BIN)
        begin
          // Complementary pair, never 11
          a_d = on;
          b_d = !on;
        end
        else
        begin
          // Sign picks positive 10 or negative 01
          a_d = on && !duty_q[gc][qhb_pkg::DUTY_SIGN];
          b_d = on && duty_q[gc][qhb_pkg::DUTY_SIGN];
        end
      end
      always_ff @(posedge CLOCK or negedge RESETN)
      begin
        if (!RESETN)
        begin
          pha_q[gc] <= 1'b0;
          phb_q[gc] <= 1'b0;
        end
        else if (CLK_EN)
        begin
          pha_q[gc] <= a_d;
          phb_q[gc] <= b_d;
        end
      end
    end
  endgenerate

  assign PHASE_A_IN = pha_q;
  assign PHASE_B_IN = phb_q;

  // ****************************************
  // Events and interrupt
  // ****************************************
  logic fault_prev_q; // Last fault level, for edge detect
  logic hot_prev_q; // Last warning level
  logic run_prev_q; // Last running level

  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      fault_prev_q <= 1'b1;
      hot_prev_q <= 1'b1;
      run_prev_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      fault_prev_q <= FAULT_N;
      hot_prev_q <= HOT_ALERT_N;
      run_prev_q <= seq_phase_en;
    end
  end

  assign irq_set[qhb_pkg::IRQ_FAULT] = fault_prev_q && !FAULT_N;
  assign irq_set[qhb_pkg::IRQ_HOT] = hot_prev_q && !HOT_ALERT_N;
  assign irq_set[qhb_pkg::IRQ_RUN] = !run_prev_q && seq_phase_en;

  // Sticky status; a new event beats a same-cycle clear
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      irq_stat_q <= '0;
    else if (CLK_EN)
    begin
      if (WR && ADDR == qhb_pkg::REG_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~WDATA[qhb_pkg::IRQ_W-1:0]) | irq_set;
      else
        irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  // Mask register
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      irq_mask_q <= '0;
    else if (CLK_EN && WR && ADDR == qhb_pkg::REG_IRQ_MASK)
      irq_mask_q <= WDATA[qhb_pkg::IRQ_W-1:0];
  end

  assign IRQ = |(irq_stat_q & irq_mask_q);

  // ****************************************
  // Read port
  // ****************************************
  // Data stand one cycle after RD, zero otherwise and when unmapped
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      rdata_q <= '0;
    else if (CLK_EN)
    begin
      rdata_q <= '0;
      if (RD)
      begin
        unique case (ADDR)
          qhb_pkg::REG_CTRL:
            rdata_q <= {28'h0000000, ctrl_mode_q, ctrl_auto_q, ctrl_run_q};
          qhb_pkg::REG_DUTY0:
            rdata_q <= {23'h0, duty_q[0]};
          qhb_pkg::REG_DUTY1:
            rdata_q <= {23'h0, duty_q[1]};
          qhb_pkg::REG_STATUS:
            rdata_q <= {27'h0, seq_state, HOT_ALERT_N, FAULT_N};
          qhb_pkg::REG_IRQ_STAT:
            rdata_q <= {29'h0, irq_stat_q};
          qhb_pkg::REG_IRQ_MASK:
            rdata_q <= {29'h0, irq_mask_q};
          default:
            rdata_q <= '0;
        endcase
      end
    end
  end

  assign RDATA = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  no_both_high_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (OUT_FLOAT_N && ctrl_mode_q != qhb_pkg::MODE_PAR && $stable(ctrl_mode_q))
      |-> (PHASE_A_IN & PHASE_B_IN) == 2'h0)
    else $error("disallowed phase code while driving");
  par_equal_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (ctrl_mode_q == qhb_pkg::MODE_PAR && $past(ctrl_mode_q) == qhb_pkg::MODE_PAR)
      |-> PHASE_A_IN == PHASE_B_IN)
    else $error("parallel phases differ");
  phase_idle_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (CLK_EN && !seq_phase_en) |=> (PHASE_A_IN == 2'h0) && (PHASE_B_IN == 2'h0))
    else $error("phases switch while not running");
  // No register write beside the event, so software cannot mask it away
  irq_level_a: assert property (@(posedge CLOCK) disable iff (!RESETN)
    (CLK_EN && !WR && irq_set[qhb_pkg::IRQ_FAULT] &&
      irq_mask_q[qhb_pkg::IRQ_FAULT]) ##1 !WR |-> IRQ ##1 IRQ)
    else $error("fault event did not raise interrupt");
  run_cov: cover property (@(posedge CLOCK) disable iff (!RESETN)
    $rose(OUT_FLOAT_N) ##[1:300] PHASE_A_IN != 2'h0);
  par_cov: cover property (@(posedge CLOCK) disable iff (!RESETN)
    ctrl_mode_q == qhb_pkg::MODE_PAR && (PHASE_A_IN & PHASE_B_IN) != 2'h0);

endmodule // qhb_ctrl
`default_nettype wire

//--- hw/qhb_pkg.sv
// Shared constants for the quad half-bridge drive controller.
// Assumes a 200 MHz CLOCK; all times are turned into cycle counts here.
package qhb_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PS = 5000; // Clock period in ps
  localparam int T_SUPPLY_NS = 2000; // Supplies settle, power-down held low
  localparam int T_SETTLE_NS = 2000; // Internal rails settle, float held low
  localparam int T_RETRY_NS = 4000; // Auto-recovery off time
  localparam int T_QUIET_NS = 100; // Phases idle before logic ref drops
  // Least times round up to whole cycles
  localparam int SUPPLY_CYC = (T_SUPPLY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int SETTLE_CYC = (T_SETTLE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RETRY_CYC = (T_RETRY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int QUIET_CYC = (T_QUIET_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TMR_W = 10; // Timer width, holds every count above

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DUTY0 = 8'h04;
  localparam logic [7:0] REG_DUTY1 = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_CMD = 8'h18;

  // Control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_AUTO = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CMD_REARM = 0;
  // Duty fields
  localparam int DUTY_W = 8;
  localparam int DUTY_SIGN = 8;
  // Status fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_HOT = 1;
  localparam int STAT_STATE_LO = 2;
  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_HOT = 1;
  localparam int IRQ_RUN = 2;

  localparam int NCH = 2; // Channels
  localparam logic [1:0] MODE_TERN = 2'h0;
  localparam logic [1:0] MODE_BIN = 2'h1;
  localparam logic [1:0] MODE_PAR = 2'h2;

  // Sequencer states
  typedef enum logic [2:0] {
    S_OFF = 3'h0,
    S_SUPPLY = 3'h1,
    S_WAKE = 3'h2,
    S_RUN = 3'h3,
    S_RETRY = 3'h4,
    S_SHUT = 3'h5,
    S_QUIET = 3'h6
  } qhb_state_t;

endpackage

//--- hw/qhb_seq.sv
// Power and float sequencer of the half-bridge drive controller.
// Assumes fault_n is synchronous to clk and active low from the stage.
`timescale 1ns/1ps
`default_nettype none
module qhb_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run_req,
  input wire logic auto_retry,
  input wire logic rearm,
  input wire logic fault_n,
  output logic power_down_n,
  output logic float_n,
  output logic logic_en,
  output logic phase_en,
  output qhb_pkg::qhb_state_t state
);

  // ****************************************
  // State and timer
  // ****************************************
  qhb_pkg::qhb_state_t state_q; // Current phase of the sequence
  qhb_pkg::qhb_state_t state_d; // Next phase
  logic [qhb_pkg::TMR_W-1:0] tmr_q; // Down-counter for waits
  logic [qhb_pkg::TMR_W-1:0] tmr_d; // Reload value on entry
  logic tmr_done; // Wait elapsed

  assign tmr_done = (tmr_q == '0);
  assign state = state_q;

  // Next state; stopping wins over everything so phases leave first
  always_comb
  begin
    state_d = state_q;
    tmr_d = (tmr_q == '0) ? tmr_q : tmr_q - 1'b1;
    unique case (state_q)
      qhb_pkg::S_OFF:
      begin
        if (run_req)
        begin
          state_d = qhb_pkg::S_SUPPLY;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::SUPPLY_CYC - 1);
        end
      end
      qhb_pkg::S_SUPPLY:
      begin
        // Power-down low while supplies rise
        if (!run_req)
          state_d = qhb_pkg::S_OFF;
        else if (tmr_done)
        begin
          state_d = qhb_pkg::S_WAKE;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::SETTLE_CYC - 1);
        end
      end
      qhb_pkg::S_WAKE, qhb_pkg::S_RETRY:
      begin
        // Float still low; raised last
        if (!run_req)
        begin
          state_d = qhb_pkg::S_QUIET;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::QUIET_CYC - 1);
        end
        else if (tmr_done)
          state_d = qhb_pkg::S_RUN;
      end
      qhb_pkg::S_RUN:
      begin
        if (!run_req)
        begin
          state_d = qhb_pkg::S_QUIET;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::QUIET_CYC - 1);
        end
        else if (!fault_n && auto_retry)
        begin
          state_d = qhb_pkg::S_RETRY;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::RETRY_CYC - 1);
        end
        else if (!fault_n)
          state_d = qhb_pkg::S_SHUT;
      end
      qhb_pkg::S_SHUT:
      begin
        // Stuck until software asks; then float goes low then high
        if (!run_req)
        begin
          state_d = qhb_pkg::S_QUIET;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::QUIET_CYC - 1);
        end
        else if (rearm)
        begin
          state_d = qhb_pkg::S_WAKE;
          tmr_d = qhb_pkg::TMR_W'(qhb_pkg::SETTLE_CYC - 1);
        end
      end
      qhb_pkg::S_QUIET:
      begin
        // Phases already removed; logic reference goes after
        if (tmr_done)
          state_d = qhb_pkg::S_OFF;
      end
      default:
        state_d = qhb_pkg::S_OFF;
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= qhb_pkg::S_OFF;
      tmr_q <= '0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end

  // ****************************************
  // Pin decode
  // ****************************************
  // Plain decode of one register; one step can change up to three state bits
  assign logic_en = (state_q != qhb_pkg::S_OFF);
  assign power_down_n = (state_q != qhb_pkg::S_OFF) &&
    (state_q != qhb_pkg::S_SUPPLY) && (state_q != qhb_pkg::S_QUIET);
  assign float_n = (state_q == qhb_pkg::S_RUN) ||
    (state_q == qhb_pkg::S_SHUT);
  assign phase_en = (state_q == qhb_pkg::S_RUN);

  // ****************************************
  // Checks
  // ****************************************
  float_last_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(float_n) |-> power_down_n && $past(power_down_n))
    else $error("float raised before power-down released");
  pd_order_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(power_down_n) |-> !float_n && logic_en)
    else $error("power-down released with float high");
  phase_before_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(logic_en) |-> !phase_en && !$past(phase_en, 2))
    else $error("logic reference dropped with phases live");
  rearm_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == qhb_pkg::S_SHUT && rearm && run_req && ce) |=> !float_n)
    else $error("rearm did not pull float low");
  shut_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == qhb_pkg::S_SHUT) |-> !phase_en ##0 float_n)
    else $error("shutdown state drives phases");
  retry_cov: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == qhb_pkg::S_RETRY ##1 state_q == qhb_pkg::S_RUN);
  shut_cov: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == qhb_pkg::S_SHUT ##1 state_q == qhb_pkg::S_WAKE);

endmodule // qhb_seq
`default_nettype wire

//--- test/qhb_stage_model.sv
// Behavioural model of the quad half-bridge power stage.
// Assumes the controller's pins and one clock to latch faults on.
`timescale 1ns/1ps
`default_nettype none
module qhb_stage_model (
  input wire logic clk,
  input wire logic power_down_n,
  input wire logic float_n,
  input wire logic logic_en,
  input wire logic [1:0] phase_a_in,
  input wire logic [1:0] phase_b_in,
  input wire logic over_current,
  input wire logic over_temp,
  input wire logic die_warm,
  output logic fault_n,
  output logic hot_alert_n,
  output logic live
);
  // ****************************************
  // Protection
  // ****************************************
  logic fault_q = 1'h0; // Latched fault, starts clear
  logic hiz; // Every switch off
  logic [1:0] high_side_a;
  logic [1:0] high_side_b;
  logic [1:0] low_side_a;
  logic [1:0] low_side_b;

  // Float low is the only way out of a latched fault
  always_ff @(posedge clk)
  begin
    if (!float_n)
      fault_q <= 1'h0;
    else if (over_current || over_temp)
      fault_q <= 1'h1;
  end

  // Open drain with pull-up: released pins read high
  assign fault_n = !fault_q;
  assign hot_alert_n = !die_warm;
  // Missing logic reference stands in for undervoltage lockout
  assign hiz = !float_n || !power_down_n
    || fault_q || !logic_en;

  // ****************************************
  // Switch decode
  // ****************************************
  // Code 11 turns both highs on; harmless only with outputs joined
  assign high_side_a = hiz ? 2'h0 : phase_a_in;
  assign high_side_b = hiz ? 2'h0 : phase_b_in;
  assign low_side_a = hiz ? 2'h0 : ~phase_a_in;
  assign low_side_b = hiz ? 2'h0 : ~phase_b_in;
  assign live = |{high_side_a, high_side_b, low_side_a, low_side_b};
endmodule // qhb_stage_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the half-bridge drive controller.
// Assumes the stage model as far side; CLK_EN drops once only.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ****************************************
  // Signals
  // ****************************************
  logic CLOCK = 1'h0;
  logic RESETN = 1'h0;
  logic CLK_EN = 1'h1; // Dropped once to check freezing
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'h0;
  logic RD = 1'h0;
  logic [31:0] RDATA;
  logic IRQ;
  logic POWER_DOWN_N;
  logic OUT_FLOAT_N;
  logic LOGIC_SUPPLY_EN;
  logic [1:0] PHASE_A_IN;
  logic [1:0] PHASE_B_IN;
  logic FAULT_N;
  logic HOT_ALERT_N;
  logic ocur = 1'h0; // Overcurrent in the stage
  logic otemp = 1'h0; // Die above shutdown level
  logic warm = 1'h0; // Die above warning level
  logic live; // Stage switches active
  int err_total = 0;
  int compares = 0;
  int n; // Cycles spent in the last wait
  logic [31:0] d; // Last word read
  logic [3:0] s0; // Phase codes seen, channel 0
  logic [3:0] s1; // Phase codes seen, channel 1
  logic [3:0] exp0 [4] = '{4'h5, 4'h6, 4'h9, 4'h5};
  logic [3:0] exp1 [4] = '{4'h1, 4'h2, 4'h1, 4'h1};

  always #2.5 CLOCK = ~CLOCK;

  qhb_ctrl i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .CLK_EN(CLK_EN),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .IRQ(IRQ), .POWER_DOWN_N(POWER_DOWN_N), .OUT_FLOAT_N(OUT_FLOAT_N),
    .LOGIC_SUPPLY_EN(LOGIC_SUPPLY_EN), .PHASE_A_IN(PHASE_A_IN),
    .PHASE_B_IN(PHASE_B_IN), .FAULT_N(FAULT_N), .HOT_ALERT_N(HOT_ALERT_N));

  qhb_stage_model i_stage (.clk(CLOCK), .power_down_n(POWER_DOWN_N),
    .float_n(OUT_FLOAT_N), .logic_en(LOGIC_SUPPLY_EN),
    .phase_a_in(PHASE_A_IN), .phase_b_in(PHASE_B_IN), .over_current(ocur),
    .over_temp(otemp), .die_warm(warm), .fault_n(FAULT_N),
    .hot_alert_n(HOT_ALERT_N), .live(live));

  // ****************************************
  // Tasks
  // ****************************************
  // Verdict and the single exit of the run
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] want);
    compares++;
    if (got !== want)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, want, got);
    end
  endtask

  // One within two cycles of a nominal count, else zero
  function automatic logic [31:0] near(input int got, input int want);
    return {31'h0, (got >= want - 2) && (got <= want + 2)};
  endfunction

  // Register write: one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'h1;
    @(posedge CLOCK);
    WR <= 1'h0;
  endtask

  // Register read: data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CLOCK);
    RD <= 1'h0;
    #1;
    d = RDATA;
  endtask

  // Waits for {logic ref, power-down, float}; a hang ends the run
  task automatic wait_pins(input logic [2:0] want, input int lim);
    #1;
    n = 0;
    while ({LOGIC_SUPPLY_EN, POWER_DOWN_N, OUT_FLOAT_N} !== want)
    begin
      @(posedge CLOCK);
      #1;
      n++;
      if (n > lim)
      begin
        chk("pins", 32'({LOGIC_SUPPLY_EN, POWER_DOWN_N, OUT_FLOAT_N}),
          32'(want));
        end_sim;
      end
    end
  endtask

  // Records every phase code over 300 cycles, more than one 256-cycle modulator period
  task automatic scan;
    s0 = 4'h0;
    s1 = 4'h0;
    repeat (3) @(posedge CLOCK);
    repeat (300)
    begin
      @(posedge CLOCK);
      #1;
      s0[{PHASE_A_IN[0], PHASE_B_IN[0]}] = 1'h1;
      s1[{PHASE_A_IN[1], PHASE_B_IN[1]}] = 1'h1;
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge CLOCK);
    RESETN <= 1'h1;
    #1;
    chk("pins_rst", 32'({LOGIC_SUPPLY_EN, POWER_DOWN_N, OUT_FLOAT_N,
      PHASE_A_IN, PHASE_B_IN, IRQ}), 32'h0);
    rd(qhb_pkg::REG_STATUS);
    chk("status_rst", d, 32'h3);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(8'hFC);
    chk("unmapped", d, 32'h0);
    rd(qhb_pkg::REG_CTRL);
    chk("ctrl_rst", d, 32'h0);
    $display("test reset done");
    // Power-up: logic ref first, power-down released next, float last
    wr(qhb_pkg::REG_DUTY0, 32'h80);
    wr(qhb_pkg::REG_IRQ_MASK, 32'h4);
    wr(qhb_pkg::REG_CTRL, 32'h1);
    wait_pins(3'h4, 4);
    chk("ph_supply", 32'({PHASE_A_IN, PHASE_B_IN}), 32'h0);
    wait_pins(3'h6, 410);
    chk("supply_cyc", near(n, qhb_pkg::SUPPLY_CYC), 32'h1);
    wait_pins(3'h7, 410);
    chk("settle_cyc", near(n, qhb_pkg::SETTLE_CYC), 32'h1);
    rd(qhb_pkg::REG_IRQ_STAT);
    chk("irq_run", 32'({d[2:0], IRQ}), 32'h9);
    wr(qhb_pkg::REG_IRQ_STAT, 32'h4);
    rd(qhb_pkg::REG_IRQ_STAT);
    chk("irq_clr", 32'({d[2:0], IRQ}), 32'h0);
    $display("test power_up done");
    // Every mode: ternary, binary, parallel, spare code as ternary
    for (int i = 0; i < 4; i++)
    begin
      wr(qhb_pkg::REG_CTRL, {28'h0, 2'(i), 2'h1});
      scan;
      chk("codes_ch0", 32'(s0), 32'(exp0[i]));
      chk("codes_ch1", 32'(s1), 32'(exp1[i]));
    end
    wr(qhb_pkg::REG_DUTY0, 32'h180);
    scan;
    chk("codes_neg", 32'(s0), 32'h3);
    $display("test modes done");
    // Thermal warning, masked then unmasked
    wr(qhb_pkg::REG_IRQ_MASK, 32'h0);
    warm <= 1'h1;
    repeat (4) @(posedge CLOCK);
    rd(qhb_pkg::REG_STATUS);
    chk("status_hot", 32'({d[4:0], IRQ}), 32'h1A);
    wr(qhb_pkg::REG_IRQ_MASK, 32'h2);
    rd(qhb_pkg::REG_IRQ_STAT);
    chk("irq_hot", 32'({d[2:0], IRQ}), 32'h5);
    warm <= 1'h0;
    wr(qhb_pkg::REG_IRQ_STAT, 32'h2);
    rd(qhb_pkg::REG_IRQ_STAT);
    chk("hot_clr", 32'({d[2:0], IRQ}), 32'h0);
    $display("test hot done");
    // Fault in shutdown mode: held off until rearm toggles float
    wr(qhb_pkg::REG_IRQ_MASK, 32'h1);
    otemp <= 1'h1;
    @(posedge CLOCK);
    otemp <= 1'h0;
    repeat (50) @(posedge CLOCK);
    #1;
    chk("flt_ph", 32'({PHASE_A_IN, PHASE_B_IN}), 32'h0);
    chk("flt_pins", 32'({LOGIC_SUPPLY_EN, POWER_DOWN_N, OUT_FLOAT_N, live,
      IRQ}), 32'h1D);
    rd(qhb_pkg::REG_STATUS);
    chk("status_shut", d, 32'h16);
    wr(qhb_pkg::REG_CMD, 32'h1);
    wait_pins(3'h6, 4);
    wait_pins(3'h7, 410);
    chk("rearm_cyc", near(n, qhb_pkg::SETTLE_CYC), 32'h1);
    rd(qhb_pkg::REG_STATUS);
    chk("status_back", 32'({d[4:0], live}), 32'h1F);
    wr(qhb_pkg::REG_IRQ_STAT, 32'h7);
    $display("test shutdown done");
    // Auto retry: repeats while the fault stays, then holds run
    wr(qhb_pkg::REG_CTRL, 32'h3);
    ocur <= 1'h1;
    wait_pins(3'h6, 8);
    wait_pins(3'h7, 810);
    chk("retry_cyc", near(n, qhb_pkg::RETRY_CYC), 32'h1);
    wait_pins(3'h6, 8);
    ocur <= 1'h0;
    wait_pins(3'h7, 810);
    repeat (50) @(posedge CLOCK);
    #1;
    chk("retry_run", 32'({LOGIC_SUPPLY_EN, POWER_DOWN_N, OUT_FLOAT_N,
      live}), 32'hF);
    $display("test retry done");
    // Freeze: a write and 30 edges pass with the clock enable low
    s0 = {PHASE_A_IN, PHASE_B_IN};
    CLK_EN <= 1'h0;
    wr(qhb_pkg::REG_CTRL, 32'h0);
    repeat (30) @(posedge CLOCK);
    #1;
    chk("frozen", 32'({LOGIC_SUPPLY_EN, POWER_DOWN_N, OUT_FLOAT_N,
      PHASE_A_IN, PHASE_B_IN}), 32'({3'h7, s0}));
    CLK_EN <= 1'h1;
    $display("test freeze done");
    // Power-down: phases gone while the logic reference still stands
    wr(qhb_pkg::REG_CTRL, 32'h0);
    wait_pins(3'h4, 6);
    @(posedge CLOCK);
    #1;
    chk("quiet_ph", 32'({PHASE_A_IN, PHASE_B_IN, live}), 32'h0);
    wait_pins(3'h0, 30);
    chk("quiet_cyc", near(n + 1, qhb_pkg::QUIET_CYC), 32'h1);
    $display("test power_down done");
    end_sim;
  end
endmodule // tb
`default_nettype wire
